/* File: flash_reset_pkg.sv */
// constants for the host-side flash reset sequencer
// assumes a 100 MHz system clock (10 ns period)
package flash_reset_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // supply setup times, microseconds
    localparam int CORE_SUPPLY_SETUP_US = 300;
    localparam int IO_SUPPLY_SETUP_US = 300;
    // warm reset duration, microseconds
    localparam int WARM_INIT_DURATION_US = 35;
    // reset low pulse minimum, nanoseconds
    localparam int INIT_PULSE_MIN_NS = 200;
    // reset high to select minimum, nanoseconds
    localparam int INIT_HIGH_TO_SELECT_NS = 50;
    // least times round up to whole cycles
    localparam int COLD_CYC =
        (CORE_SUPPLY_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARM_CYC =
        (WARM_INIT_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC =
        (INIT_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYC =
        (INIT_HIGH_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // reset value of the sequencer's cycle counter
    localparam logic [15:0] CNT_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_POWER   = 3'b000,
        ST_PULSE   = 3'b001,
        ST_WARM    = 3'b010,
        ST_HIGH    = 3'b011,
        ST_READY   = 3'b100,
        ST_WAITRDY = 3'b101
    } seq_state_t;
endpackage : flash_reset_pkg

/* File: pin_sync3.sv */
// three-stage synchroniser for a pin from outside the clock domain
// output changes only once the second and third stages agree
`timescale 1ns/1ps
module pin_sync3 (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PIN,
    output logic LEVEL
);
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic level_r;
    logic level_nxt;

    always_comb begin
        stage_nxt = {stage_r[1:0], PIN};
        level_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : level_r;
    end

    // pins idle high; reset value high avoids a false busy/low reading
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            stage_r <= 3'h7;
            level_r <= 1'b1;
        end else begin
            stage_r <= stage_nxt;
            level_r <= level_nxt;
        end
    end

    assign LEVEL = level_r;
endmodule : pin_sync3

/* File: flash_reset_host.sv */
// host-side reset sequencer for an asynchronous parallel nor flash
// drives the flash reset and chip-select pins; watches ready_busy_n.
// the read/write engine behind it may select at any time; CE_N is held high here until READY.
`timescale 1ns/1ps
module flash_reset_host (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic WARM_REQ,
    input wire logic ACCESS_CE_N,
    input wire logic READY_BUSY_N,
    output logic RESET_N,
    output logic CE_N,
    output logic READY,
    output logic BUSY_SEEN,
    output logic TIMEOUT_ERR
);
    ////////////////////////////////////////////////////////////////////////
    // synchronised ready/busy pin
    logic rdy_lvl;

    pin_sync3 u_rdy_sync (
        .CLK(CLK),
        .RSTN(RSTN),
        .PIN(READY_BUSY_N),
        .LEVEL(rdy_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer state
    flash_reset_pkg::seq_state_t state_r;
    flash_reset_pkg::seq_state_t state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] total_r;
    logic [15:0] total_nxt;
    logic rst_n_r;
    logic rst_n_nxt;
    logic ready_r;
    logic ready_nxt;
    logic busy_seen_r;
    logic busy_seen_nxt;
    logic tmo_r;
    logic tmo_nxt;
    logic cold_done_r;
    logic cold_done_nxt;

    localparam logic [15:0] COLD_N = 16'(flash_reset_pkg::COLD_CYC);
    localparam logic [15:0] WARM_N = 16'(flash_reset_pkg::WARM_CYC);
    localparam logic [15:0] PULSE_N = 16'(flash_reset_pkg::PULSE_CYC);
    localparam logic [15:0] HIGH_N = 16'(flash_reset_pkg::HIGH_CYC);

    function automatic logic reached(input logic [15:0] c,
                                     input logic [15:0] lim);
        reached = (c >= lim - 16'h0001);
    endfunction : reached

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 16'h0001;
        total_nxt = (total_r == 16'hFFFF) ? total_r : total_r + 16'h0001;
        rst_n_nxt = rst_n_r;
        ready_nxt = 1'b0;
        busy_seen_nxt = busy_seen_r;
        tmo_nxt = tmo_r;
        cold_done_nxt = cold_done_r;
        case (state_r)
            // hold reset low through the whole cold interval; flash
            // ignores it then, but warm time is counted past setups
            flash_reset_pkg::ST_POWER: begin
                rst_n_nxt = 1'b0;
                if (reached(cnt_r, COLD_N)) begin
                    state_nxt = flash_reset_pkg::ST_WARM;
                    cnt_nxt = flash_reset_pkg::CNT_RST;
                end
            end
            flash_reset_pkg::ST_PULSE: begin
                rst_n_nxt = 1'b0;
                if (reached(cnt_r, PULSE_N)) begin
                    state_nxt = flash_reset_pkg::ST_WARM;
                    cnt_nxt = flash_reset_pkg::CNT_RST;
                end
            end
            // keep reset low until the whole warm time has passed,
            // so the reset low time alone (pulse plus warm state) always covers the warm duration
            flash_reset_pkg::ST_WARM: begin
                rst_n_nxt = 1'b0;
                if (reached(cnt_r, WARM_N)) begin
                    state_nxt = flash_reset_pkg::ST_HIGH;
                    cnt_nxt = flash_reset_pkg::CNT_RST;
                    rst_n_nxt = 1'b1;
                end
            end
            flash_reset_pkg::ST_HIGH: begin
                rst_n_nxt = 1'b1;
                if (reached(cnt_r, HIGH_N)) begin
                    state_nxt = flash_reset_pkg::ST_WAITRDY;
                    total_nxt = flash_reset_pkg::CNT_RST;
                end
            end
            // a cold rerun can take the full cold time; bound the wait
            flash_reset_pkg::ST_WAITRDY: begin
                if (rdy_lvl) begin
                    state_nxt = flash_reset_pkg::ST_READY;
                    cold_done_nxt = 1'b1;
                end else if (reached(total_r, COLD_N)) begin
                    tmo_nxt = 1'b1;
                    cold_done_nxt = 1'b0;
                    state_nxt = flash_reset_pkg::ST_READY;
                end
            end
            flash_reset_pkg::ST_READY: begin
                ready_nxt = 1'b1;
                if (WARM_REQ) begin
                    state_nxt = flash_reset_pkg::ST_PULSE;
                    cnt_nxt = flash_reset_pkg::CNT_RST;
                    ready_nxt = 1'b0;
                    rst_n_nxt = 1'b0;
                    tmo_nxt = 1'b0;
                    busy_seen_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = flash_reset_pkg::ST_POWER;
                cnt_nxt = flash_reset_pkg::CNT_RST;
            end
        endcase
        // set after the request clear, so a busy seen then is kept
        if (!rdy_lvl) begin
            busy_seen_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_r <= flash_reset_pkg::ST_POWER;
            cnt_r <= flash_reset_pkg::CNT_RST;
            total_r <= flash_reset_pkg::CNT_RST;
            rst_n_r <= 1'b0;
            ready_r <= 1'b0;
            busy_seen_r <= 1'b0;
            tmo_r <= 1'b0;
            cold_done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            total_r <= total_nxt;
            rst_n_r <= rst_n_nxt;
            ready_r <= ready_nxt;
            busy_seen_r <= busy_seen_nxt;
            tmo_r <= tmo_nxt;
            cold_done_r <= cold_done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chip select: forced high until ready, so the first access after
    // reset is always a fresh high-to-low edge
    logic ce_n_r;
    logic ce_n_nxt;

    always_comb begin
        // a warm request closes select at once, never low under reset
        ce_n_nxt = (ready_r && ready_nxt) ? ACCESS_CE_N : 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ce_n_r <= 1'b1;
        end else begin
            ce_n_r <= ce_n_nxt;
        end
    end

    assign RESET_N = rst_n_r;
    assign CE_N = ce_n_r;
    assign READY = ready_r;
    assign BUSY_SEEN = busy_seen_r;
    assign TIMEOUT_ERR = tmo_r;
endmodule : flash_reset_host

/* File: flash_reset_host_properties.sv */
// concurrent checks on the flash reset sequencer ports
// bound to every flash_reset_host instance; one clock, sync reset
`timescale 1ns/1ps
module flash_reset_props (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic WARM_REQ,
    input wire logic ACCESS_CE_N,
    input wire logic READY_BUSY_N,
    input wire logic RESET_N,
    input wire logic CE_N,
    input wire logic READY,
    input wire logic BUSY_SEEN,
    input wire logic TIMEOUT_ERR
);
    logic [15:0] lo_r, lo_nxt, hi_r, hi_nxt;
    // high count saturates: the host may idle ready for a long time
    always_comb begin
        lo_nxt = RESET_N ? 16'h0000 : lo_r + 16'h0001;
        hi_nxt = !RESET_N ? 16'h0000 : (&hi_r ? hi_r : hi_r + 16'h0001);
    end
    always_ff @(posedge CLK) begin
        lo_r <= RSTN ? lo_nxt : 16'h0000;
        hi_r <= RSTN ? hi_nxt : 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_request; READY && WARM_REQ; endsequence
    sequence s_release; $rose(RESET_N); endsequence
    sequence s_settle; !READY [*5]; endsequence
    warm_answer_a: assert property (s_request |=> !READY && !RESET_N)
        else $error("warm request not answered");
    release_gap_a: assert property (s_release |-> s_settle)
        else $error("ready too soon after reset release");
    pulse_sum_a: assert property (s_release |-> lo_r >=
        flash_reset_pkg::PULSE_CYC + flash_reset_pkg::WARM_CYC)
        else $error("reset low too short");
    select_high_a: assert property ($fell(CE_N)
        |-> hi_r >= flash_reset_pkg::HIGH_CYC)
        else $error("select low too soon after reset high");
    ce_blocked_a: assert property (!READY |=> CE_N)
        else $error("select while not ready");
    ce_follow_a: assert property (READY && !WARM_REQ
        |=> CE_N == $past(ACCESS_CE_N))
        else $error("select does not follow engine");
    ready_pin_a: assert property ($rose(READY) && !TIMEOUT_ERR
        |-> $past(READY_BUSY_N, 2) && $past(READY_BUSY_N, 3))
        else $error("ready while flash busy");
    ready_reset_a: assert property (READY |-> RESET_N)
        else $error("ready with reset low");
    ready_stays_a: assert property (READY && !WARM_REQ |=> READY)
        else $error("ready dropped without request");
endmodule : flash_reset_props
bind flash_reset_host flash_reset_props u_props (.CLK(CLK), .RSTN(RSTN),
    .WARM_REQ(WARM_REQ), .ACCESS_CE_N(ACCESS_CE_N),
    .READY_BUSY_N(READY_BUSY_N), .RESET_N(RESET_N), .CE_N(CE_N),
    .READY(READY), .BUSY_SEEN(BUSY_SEEN), .TIMEOUT_ERR(TIMEOUT_ERR));

/* File: flash_model.sv */
// behavioural flash: ready/busy from cold and warm reset sequences
// assumes power is applied at time zero; pin has a pull-up
`timescale 1ns/1ps
module flash_model #(
    parameter int COLD = 32'h0000_7530,
    parameter int WARM = 32'h0000_0bb8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stuck,
    output logic ready_busy_n
);
    int cnt = COLD;
    logic prev = 1'b1;
    always @(posedge clk) begin
        if (cnt != 0) cnt <= cnt - 1;
        else if (prev && !reset_n) cnt <= WARM;
        prev <= reset_n;
    end
    // stuck stands for a failed warm reset that never ends
    assign ready_busy_n = (cnt == 0) && !stuck;
endmodule : flash_model

/* File: flash_reset_host_tb.sv */
// self-checking bench: cold start, warm reset, warm reset timing out
// assumes flash_reset_pkg and the flash model are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module flash_reset_host_tb;
    typedef struct {logic [1:0] flags; int lo;} note_t;
    logic CLK, RSTN, WARM_REQ, ACCESS_CE_N, READY_BUSY_N, RESET_N, CE_N;
    logic READY, BUSY_SEEN, TIMEOUT_ERR, stuck, rdy_q;
    int err_count, n_compared, run, last, seed, k;
    note_t notes[$];
    note_t n;
    flash_reset_host DUT (.CLK(CLK), .RSTN(RSTN), .WARM_REQ(WARM_REQ),
        .ACCESS_CE_N(ACCESS_CE_N), .READY_BUSY_N(READY_BUSY_N),
        .RESET_N(RESET_N), .CE_N(CE_N), .READY(READY),
        .BUSY_SEEN(BUSY_SEEN), .TIMEOUT_ERR(TIMEOUT_ERR));
    flash_model FM (.clk(CLK), .reset_n(RESET_N), .stuck(stuck),
        .ready_busy_n(READY_BUSY_N));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task wait_ready;
        k = 0;
        do begin @(posedge CLK); k++; end
        while (READY !== 1'b1 && k < 40000);
        if (k >= 40000) begin err_count++; wrap_up(); end
    endtask : wait_ready
    task warm(input logic s);
        @(posedge CLK);
        WARM_REQ <= 1'b1;
        stuck <= s;
        notes.push_back('{{s, 1'b1}, flash_reset_pkg::PULSE_CYC
            + flash_reset_pkg::WARM_CYC});
        @(posedge CLK);
        WARM_REQ <= 1'b0;
        @(posedge CLK);
        wait_ready();
        stuck <= 1'b0;
    endtask : warm
    // engine select is random throughout; it must be gated until ready
    always @(posedge CLK) ACCESS_CE_N <= 1'($random(seed));
    always @(posedge CLK) begin
        if (RESET_N === 1'b0) run++;
        else if (run != 0) begin last = run; run = 0; end
        if (READY === 1'b1 && rdy_q === 1'b0) begin
            n = notes.pop_front();
            `CHK({TIMEOUT_ERR, BUSY_SEEN}, n.flags)
            `CHK(last >= n.lo, 1'b1)
        end
        rdy_q = READY;
    end
    initial begin
        seed = 32'h0000_e150;
        {RSTN, WARM_REQ, stuck, rdy_q} = 4'h0;
        ACCESS_CE_N = 1'b1;
        {run, last, err_count, n_compared} = {4{32'h0000_0000}};
        notes.push_back('{2'h1, flash_reset_pkg::COLD_CYC
            + flash_reset_pkg::WARM_CYC});
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        wait_ready();
        warm(1'b0);
        warm(1'b1);
        repeat (10) @(posedge CLK);
        wrap_up();
    end
endmodule : flash_reset_host_tb
